//--- dmag_pkg.sv
// constants for data memory address generation
package dmag_pkg;
    // ************************************************
    // address space
    // ************************************************
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 8;
    localparam logic [7:0]  LIT_OFS_MAX    = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  SFR_BANK       = 4'hf;
    // ************************************************
    // pointer and virtual register map (low byte in bank f)
    // ************************************************
    localparam logic [7:0]  PTR0_LOW_LO    = 8'he9;
    localparam logic [7:0]  PTR0_HIGH_LO   = 8'hea;
    localparam logic [7:0]  PTR1_LOW_LO    = 8'he1;
    localparam logic [7:0]  PTR1_HIGH_LO   = 8'he2;
    localparam logic [7:0]  PTR2_LOW_LO    = 8'hd9;
    localparam logic [7:0]  PTR2_HIGH_LO   = 8'hda;
    localparam logic [7:0]  VIRT0_BASE_LO  = 8'heb;
    localparam logic [7:0]  VIRT1_BASE_LO  = 8'he3;
    localparam logic [7:0]  VIRT2_BASE_LO  = 8'hdb;
    localparam logic [7:0]  VIRT_COUNT     = 8'h05;
    // virtual register kinds, index from base: indirect_port_plus_working, preinc, postinc,
    // postdec, plain
    typedef enum logic [2:0] {
        VK_INDIRECT_PORT_PLUS_WORKING   = 3'b000,
        VK_PREINC  = 3'b001,
        VK_POSTINC = 3'b010,
        VK_POSTDEC = 3'b011,
        VK_PLAIN   = 3'b100
    } dmag_vkind_t;
    localparam logic [11:0] PTR_RESET      = 12'h000;
    localparam logic [7:0]  READ_ZERO      = 8'h00;
endpackage

//--- dmag_ptr.sv
// one pointer register pair with direct and indirect update
`timescale 1ns/1ps
`default_nettype none
module dmag_ptr
    import dmag_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wr_low_i,
    input  wire logic              wr_high_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              step_i,
    input  wire logic              step_down_i,
    output logic      [11:0]       ptr_o
);
    logic [11:0] ptr_q;
    logic [11:0] ptr_d;

    // direct writes win over any pending step
    always_comb begin
        ptr_d = ptr_q;
        if (wr_low_i || wr_high_i) begin
            if (wr_low_i) begin
                ptr_d[7:0] = wdata_i;
            end
            if (wr_high_i) begin
                ptr_d[11:8] = wdata_i[3:0];
            end
        end else if (step_i) begin
            ptr_d = step_down_i ? ptr_q - 12'h001 : ptr_q + 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q <= PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    assign ptr_o = ptr_q;
endmodule
`default_nettype wire

//--- dmag_top.sv
// operand address generation for the core data memory
// Contract
// - indirect read of virtual register returns zero
// - indirect write to virtual register does nothing
// - write onto pointer pair stores, no step
// - pointers are direct-accessible special registers
// - indirect access reaches other special registers
// - plus-working port addresses pointer plus W
// - indexed mode only with fuse set
// - extended set leaves map and space unchanged
// - pointers zero and one unchanged when extended
// - indexed only when a=0 and f<=5Fh
// - indexed target is pointer two plus offset
// - else bank select or access bank address
// - indexed applies to byte and bit ops only
// - a=1 or f>=60h stays direct
`timescale 1ns/1ps
`default_nettype none
module dmag_top
    import dmag_pkg::*;
(
    input  wire logic              CORE_CLK_I,
    input  wire logic              RST_I,
    input  wire logic              EXT_SET_FUSE_I,
    input  wire logic              OP_VALID_I,
    input  wire logic              OP_FILE_I,
    input  wire logic              OP_WRITE_I,
    input  wire logic              ACCESS_SEL_I,
    input  wire logic [7:0]        FILE_ADDR_I,
    input  wire logic [3:0]        BANK_SELECT_I,
    input  wire logic [7:0]        WORKING_I,
    input  wire logic [7:0]        WDATA_I,
    input  wire logic [7:0]        MEM_RDATA_I,
    output logic      [11:0]       MEM_ADDR_O,
    output logic                   MEM_RD_O,
    output logic                   MEM_WR_O,
    output logic      [7:0]        MEM_WDATA_O,
    output logic      [7:0]        RDATA_O,
    output logic      [11:0]       POINTER_ZERO_O,
    output logic      [11:0]       POINTER_ONE_O,
    output logic      [11:0]       POINTER_TWO_O
);
    // ************************************************
    // decode helpers
    // ************************************************
    function automatic logic is_sfr(input logic [11:0] a,
                                    input logic [7:0] lo);
        return (a[11:8] == SFR_BANK) && (a[7:0] == lo);
    endfunction

    // which virtual register of a pointer, valid when hit
    function automatic logic virt_hit(input logic [11:0] a,
                                      input logic [7:0] base);
        return (a[11:8] == SFR_BANK) && (a[7:0] >= base)
            && (a[7:0] < base + VIRT_COUNT);
    endfunction

    function automatic logic [2:0] virt_kind(input logic [11:0] a,
                                             input logic [7:0] base);
        logic [7:0] diff;
        diff = a[7:0] - base;
        return diff[2:0];
    endfunction

    function automatic logic [11:0] eff_addr(input logic [11:0] p,
                                             input logic [2:0] k,
                                             input logic [7:0] w);
        logic [11:0] r;
        r = p;
        if (k == VK_INDIRECT_PORT_PLUS_WORKING) begin
            r = p + {4'h0, w};
        end else if (k == VK_PREINC) begin
            r = p + 12'h001;
        end
        return r;
    endfunction

    // ************************************************
    // direct address formation
    // ************************************************
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic [11:0] ptr2;
    wire         indexed  = EXT_SET_FUSE_I && OP_FILE_I && !ACCESS_SEL_I
                            && (FILE_ADDR_I <= LIT_OFS_MAX);
    wire [11:0]  idx_addr = ptr2 + {4'h0, FILE_ADDR_I};
    wire [11:0]  acc_addr = (FILE_ADDR_I < ACCESS_SPLIT)
                            ? {4'h0, FILE_ADDR_I}
                            : {SFR_BANK, FILE_ADDR_I};
    // a=1 or high file address keeps direct meaning
    wire [11:0]  dir_addr = indexed ? idx_addr
                          : ACCESS_SEL_I ? {BANK_SELECT_I, FILE_ADDR_I}
                          : acc_addr;

    // ************************************************
    // first level virtual register resolve
    // ************************************************
    wire         hit0 = virt_hit(dir_addr, VIRT0_BASE_LO);
    wire         hit1 = virt_hit(dir_addr, VIRT1_BASE_LO);
    wire         hit2 = virt_hit(dir_addr, VIRT2_BASE_LO);
    wire [2:0]   kind = hit0 ? virt_kind(dir_addr, VIRT0_BASE_LO)
                      : hit1 ? virt_kind(dir_addr, VIRT1_BASE_LO)
                      : virt_kind(dir_addr, VIRT2_BASE_LO);
    wire [11:0]  sel_ptr = hit0 ? ptr0 : hit1 ? ptr1 : ptr2;
    wire         indirect = OP_VALID_I && (hit0 || hit1 || hit2);
    wire [11:0]  tgt = indirect ? eff_addr(sel_ptr, kind, WORKING_I)
                                : dir_addr;

    // an indirect target that is itself virtual is a dead access
    wire         tgt_virt = indirect && (virt_hit(tgt, VIRT0_BASE_LO)
                            || virt_hit(tgt, VIRT1_BASE_LO)
                            || virt_hit(tgt, VIRT2_BASE_LO));

    // ************************************************
    // pointer register writes and steps
    // ************************************************
    wire         wr_any = OP_VALID_I && OP_WRITE_I && !tgt_virt;
    wire         w0l = wr_any && is_sfr(tgt, PTR0_LOW_LO);
    wire         w0h = wr_any && is_sfr(tgt, PTR0_HIGH_LO);
    wire         w1l = wr_any && is_sfr(tgt, PTR1_LOW_LO);
    wire         w1h = wr_any && is_sfr(tgt, PTR1_HIGH_LO);
    wire         w2l = wr_any && is_sfr(tgt, PTR2_LOW_LO);
    wire         w2h = wr_any && is_sfr(tgt, PTR2_HIGH_LO);
    wire         tgt_ptr = is_sfr(tgt, PTR0_LOW_LO)
                        || is_sfr(tgt, PTR0_HIGH_LO)
                        || is_sfr(tgt, PTR1_LOW_LO)
                        || is_sfr(tgt, PTR1_HIGH_LO)
                        || is_sfr(tgt, PTR2_LOW_LO)
                        || is_sfr(tgt, PTR2_HIGH_LO);
    // steps suppressed on dead accesses and on pointer writes
    wire         stepping = indirect && !tgt_virt && (kind != VK_INDIRECT_PORT_PLUS_WORKING)
                            && (kind != VK_PLAIN) && !(OP_WRITE_I && tgt_ptr);
    wire         down = (kind == VK_POSTDEC);

    dmag_ptr u_ptr0 (
        .clk_i       (CORE_CLK_I),
        .rst_i       (RST_I),
        .wr_low_i    (w0l),
        .wr_high_i   (w0h),
        .wdata_i     (WDATA_I),
        .step_i      (stepping && hit0),
        .step_down_i (down),
        .ptr_o       (ptr0)
    );
    dmag_ptr u_ptr1 (
        .clk_i       (CORE_CLK_I),
        .rst_i       (RST_I),
        .wr_low_i    (w1l),
        .wr_high_i   (w1h),
        .wdata_i     (WDATA_I),
        .step_i      (stepping && hit1),
        .step_down_i (down),
        .ptr_o       (ptr1)
    );
    dmag_ptr u_ptr2 (
        .clk_i       (CORE_CLK_I),
        .rst_i       (RST_I),
        .wr_low_i    (w2l),
        .wr_high_i   (w2h),
        .wdata_i     (WDATA_I),
        .step_i      (stepping && hit2),
        .step_down_i (down),
        .ptr_o       (ptr2)
    );

    // ************************************************
    // read data selection
    // ************************************************
    // pointer bytes come from here; other special registers pass to memory
    wire [7:0]   ptr_rd = is_sfr(tgt, PTR0_LOW_LO)  ? ptr0[7:0]
                        : is_sfr(tgt, PTR0_HIGH_LO) ? {4'h0, ptr0[11:8]}
                        : is_sfr(tgt, PTR1_LOW_LO)  ? ptr1[7:0]
                        : is_sfr(tgt, PTR1_HIGH_LO) ? {4'h0, ptr1[11:8]}
                        : is_sfr(tgt, PTR2_LOW_LO)  ? ptr2[7:0]
                        : {4'h0, ptr2[11:8]};
    wire [7:0]   rd_sel = tgt_virt ? READ_ZERO
                        : tgt_ptr  ? ptr_rd
                        : MEM_RDATA_I;
    wire         mem_ok = OP_VALID_I && !tgt_virt && !tgt_ptr && !(!indirect
                          && (hit0 || hit1 || hit2));

    logic [7:0]  rdata_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rdata_q <= READ_ZERO;
        end else if (OP_VALID_I && !OP_WRITE_I) begin
            rdata_q <= rd_sel;
        end
    end

    // handshake and address outputs are combinational by design
    assign MEM_ADDR_O     = tgt;
    assign MEM_RD_O       = mem_ok && !OP_WRITE_I;
    assign MEM_WR_O       = mem_ok && OP_WRITE_I;
    assign MEM_WDATA_O    = WDATA_I;
    assign RDATA_O        = rdata_q;
    assign POINTER_ZERO_O = ptr0;
    assign POINTER_ONE_O  = ptr1;
    assign POINTER_TWO_O  = ptr2;
endmodule
`default_nettype wire

//--- dmag_checker.sv
// assertion checker for data memory address generation
`timescale 1ns/1ps
`default_nettype none
module dmag_checker
    import dmag_pkg::*;
(
    input wire logic        CORE_CLK_I,
    input wire logic        RST_I,
    input wire logic        EXT_SET_FUSE_I,
    input wire logic        OP_VALID_I,
    input wire logic        OP_FILE_I,
    input wire logic        OP_WRITE_I,
    input wire logic        ACCESS_SEL_I,
    input wire logic [7:0]  FILE_ADDR_I,
    input wire logic [3:0]  BANK_SELECT_I,
    input wire logic [7:0]  WORKING_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic [7:0]  MEM_RDATA_I,
    input wire logic [11:0] MEM_ADDR_O,
    input wire logic        MEM_RD_O,
    input wire logic        MEM_WR_O,
    input wire logic [7:0]  MEM_WDATA_O,
    input wire logic [7:0]  RDATA_O,
    input wire logic [11:0] POINTER_ZERO_O,
    input wire logic [11:0] POINTER_TWO_O
);
    // ************************************************
    // helpers
    // ************************************************
    wire logic [7:0]  p0l = POINTER_ZERO_O[7:0];
    wire logic        virt0 = POINTER_ZERO_O[11:8] == 4'hf
        && ((p0l >= 8'hdb && p0l <= 8'hdf) || (p0l >= 8'he3 && p0l <= 8'he7)
        || (p0l >= 8'heb && p0l <= 8'hef));
    wire logic        acc = OP_VALID_I && !ACCESS_SEL_I;
    wire logic        idx = acc && EXT_SET_FUSE_I && OP_FILE_I
        && FILE_ADDR_I <= LIT_OFS_MAX;
    wire logic [11:0] isum = POINTER_TWO_O + {4'h0, FILE_ADDR_I};
    wire logic [11:0] psum = POINTER_ZERO_O + {4'h0, WORKING_I};
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // a dead write leaves both watched pointers as they were
    sequence s_dead_write;
        !MEM_WR_O ##1 POINTER_ZERO_O == $past(POINTER_ZERO_O)
            && POINTER_TWO_O == $past(POINTER_TWO_O);
    endsequence
    // ************************************************
    // assertions
    // ************************************************
    read_return_a: assert property (OP_VALID_I && !OP_WRITE_I
        && MEM_RD_O |=> RDATA_O == $past(MEM_RDATA_I))
        else $error("read data lost");
    write_data_a: assert property (MEM_WR_O
        |-> OP_VALID_I && OP_WRITE_I && MEM_WDATA_O == WDATA_I)
        else $error("bad write strobe");
    fuse_off_a: assert property (acc && !EXT_SET_FUSE_I
        && FILE_ADDR_I < ACCESS_SPLIT |-> MEM_ADDR_O == {4'h0, FILE_ADDR_I})
        else $error("indexed without fuse");
    index_sum_a: assert property (idx && isum[11:8] != SFR_BANK
        |-> MEM_ADDR_O == isum) else $error("indexed address wrong");
    bank_select_a: assert property (OP_VALID_I && ACCESS_SEL_I
        && BANK_SELECT_I != SFR_BANK
        |-> MEM_ADDR_O == {BANK_SELECT_I, FILE_ADDR_I})
        else $error("banked address wrong");
    upper_access_a: assert property (acc
        && FILE_ADDR_I >= ACCESS_SPLIT
        && (FILE_ADDR_I < 8'hd9 || FILE_ADDR_I > 8'hef)
        |-> MEM_ADDR_O == {SFR_BANK, FILE_ADDR_I})
        else $error("upper access address wrong");
    non_file_a: assert property (acc && !OP_FILE_I
        && FILE_ADDR_I < ACCESS_SPLIT |-> MEM_ADDR_O == {4'h0, FILE_ADDR_I})
        else $error("non file op indexed");
    virt_read_a: assert property (acc && !OP_WRITE_I
        && FILE_ADDR_I == 8'hef && virt0
        |-> !MEM_RD_O ##1 RDATA_O == READ_ZERO)
        else $error("virtual read not zero");
    virt_write_a: assert property (acc && OP_WRITE_I
        && FILE_ADDR_I == 8'hef && virt0 |-> s_dead_write)
        else $error("virtual write acted");
    self_write_a: assert property (acc && OP_WRITE_I
        && FILE_ADDR_I == 8'hde && POINTER_TWO_O == 12'hfd9
        |=> POINTER_TWO_O == {4'hf, $past(WDATA_I)})
        else $error("pointer self write stepped");
    plus_work_a: assert property (acc && FILE_ADDR_I == 8'heb
        && psum[11:8] != SFR_BANK |-> MEM_ADDR_O == psum)
        else $error("plus working address wrong");
    ptr_high_a: assert property (acc && OP_WRITE_I
        && FILE_ADDR_I == 8'hea
        |=> {4'h0, POINTER_ZERO_O[11:8]} == ($past(WDATA_I) & 8'h0f))
        else $error("pointer high nibble wrong");
endmodule
bind dmag_top dmag_checker u_chk (.*);
`default_nettype wire

//--- dmag_top_bench.sv
// self-checking bench for data memory address generation
`timescale 1ns/1ps
`default_nettype none
module dmag_top_bench;
    import dmag_pkg::*;
    logic        clk, rst, fuse, file, wr, acc, valid;
    logic [7:0]  fa, wd, mrd, wk;
    logic [3:0]  bank_select_register;
    logic [11:0] addr, p0, p1, p2, last;
    logic        mrdo, mwro;
    logic [7:0]  mwd, rdat;
    logic [26:0] r;
    int          num_errors = 0, tests_run = 0, cycles = 0;
    // rows: fuse, file, a, bank, file address, expected address
    logic [26:0] rows [8] = '{{3'b010, 4'h0, 8'h10, 12'h010},
        {3'b110, 4'h0, 8'h10, 12'h000}, {3'b110, 4'h0, 8'h5f, 12'h04f},
        {3'b110, 4'h0, 8'h60, 12'hf60}, {3'b111, 4'h3, 8'h10, 12'h310},
        {3'b100, 4'h0, 8'h10, 12'h010}, {3'b011, 4'h5, 8'h20, 12'h520},
        {3'b110, 4'h0, 8'h00, 12'hff0}};
    dmag_top DUT (.CORE_CLK_I(clk), .RST_I(rst), .EXT_SET_FUSE_I(fuse),
        .OP_VALID_I(valid), .OP_FILE_I(file), .OP_WRITE_I(wr),
        .ACCESS_SEL_I(acc), .FILE_ADDR_I(fa), .BANK_SELECT_I(bank_select_register),
        .WORKING_I(wk), .WDATA_I(wd), .MEM_RDATA_I(mrd),
        .MEM_ADDR_O(addr), .MEM_RD_O(mrdo), .MEM_WR_O(mwro),
        .MEM_WDATA_O(mwd), .RDATA_O(rdat), .POINTER_ZERO_O(p0),
        .POINTER_ONE_O(p1), .POINTER_TWO_O(p2));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize;
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [11:0] s, e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // m is fuse, file, write, a; d is write data and memory read data
    task automatic op(input logic [3:0] m, input logic [7:0] f, d,
                      input logic [3:0] b);
        @(posedge clk);
        {fuse, file, wr, acc} <= m;
        fa <= f;
        wd <= d;
        mrd <= d;
        bank_select_register <= b;
        valid <= 1'b1;
        @(negedge clk);
    endtask
    task automatic idle;
        @(posedge clk);
        valid <= 1'b0;
        @(negedge clk);
    endtask
    // hang guard, well above the 39 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize;
        end
    end
    initial begin
        {rst, fuse, file, wr, acc, valid} = 6'b100000;
        {fa, wd, mrd, bank_select_register} = 28'h0;
        wk = 8'h10;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("ptr0", p0, 12'h000);
        op(4'b0110, 8'hd9, 8'hf0, 4'h0);
        op(4'b0110, 8'hda, 8'h0f, 4'h0);
        op(4'b0110, 8'he9, 8'h23, 4'h0);
        op(4'b0110, 8'hea, 8'hf1, 4'h0);
        op(4'b0100, 8'hea, 8'h00, 4'h0);
        chk("ptr0", p0, 12'h123);
        idle;
        chk("ptr high", rdat, 12'h001);
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            op({r[26:25], 1'b0, r[24]}, r[19:12], r[19:12] ^ 8'h3c, r[23:20]);
            chk("addr", addr, r[11:0]);
            if (i > 0) chk("rdata", rdat, last);
            last = {4'h0, r[19:12] ^ 8'h3c};
        end
        op(4'b1100, 8'hef, 8'h77, 4'h0);
        chk("rdata", rdat, last);
        chk("ptr0 port", addr, 12'h123);
        op(4'b1100, 8'heb, 8'h00, 4'h0);
        chk("plus w", addr, 12'h133);
        chk("rdata", rdat, 12'h077);
        op(4'b0110, 8'he9, 8'h80, 4'h0);
        op(4'b0110, 8'hea, 8'h0f, 4'h0);
        op(4'b0110, 8'hef, 8'h5a, 4'h0);
        chk("sfr write", {mwro, addr[10:0]}, 12'hf80);
        chk("wdata", {4'h0, mwd}, 12'h05a);
        op(4'b0110, 8'he9, 8'he7, 4'h0);
        op(4'b0100, 8'hef, 8'h5a, 4'h0);
        chk("virt rd", mrdo, 12'h000);
        op(4'b0110, 8'hef, 8'h99, 4'h0);
        chk("virt wr", mwro, 12'h000);
        chk("virt rdata", rdat, 12'h000);
        op(4'b0110, 8'hd9, 8'hd9, 4'h0);
        chk("ptr0", p0, 12'hfe7);
        chk("ptr1", p1, 12'h000);
        op(4'b0110, 8'hde, 8'h40, 4'h0);
        idle;
        chk("ptr2", p2, 12'hf40);
        // stepping ports of pointer one, then plus working with a new w
        op(4'b0100, 8'he5, 8'h11, 4'h0);
        chk("postinc addr", addr, 12'h000);
        op(4'b0100, 8'he4, 8'h11, 4'h0);
        chk("preinc addr", addr, 12'h002);
        op(4'b0100, 8'he6, 8'h11, 4'h0);
        chk("postdec addr", addr, 12'h002);
        chk("ptr1 step", p1, 12'h002);
        idle;
        chk("ptr1 dec", p1, 12'h001);
        @(posedge clk);
        wk <= 8'h05;
        op(4'b0100, 8'he3, 8'h11, 4'h0);
        chk("plus w1", addr, 12'h006);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("ptr0 rst", p0, 12'h000);
        chk("rdata rst", rdat, 12'h000);
        summarize;
    end
endmodule
`default_nettype wire
